// File: logic/dss_sequencer.sv
// Dual-slope conversion sequencer with display scan and an APB register slave.
// Assumes the gate and comparator pins are asynchronous to mclk, and that the
// comparator reads high while the integrator shows a positive input.
// Counts are mclk edges with ce high; ce low freezes
// conversion, scan and register bus together.
// Limitation: strobe is low one mclk, not half a
// clock, as all logic runs on the rising edge.
// Over-range needs the full deintegrate length;
// a shortened one never reaches 20000.

`default_nettype none

module dss_sequencer #(
    parameter logic [15:0] CYC_CLKS    = dss_pkg::CYC_CLKS,
    parameter logic [15:0] SI_CLKS     = dss_pkg::SI_CLKS,
    parameter logic [15:0] DI_CLKS     = dss_pkg::DI_CLKS,
    parameter logic [15:0] ZI_OVR_CLKS = dss_pkg::ZI_OVR_CLKS
) (
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire logic            ce,
    input  wire logic            runHoldPin,
    input  wire logic            cmpPin,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    output dss_pkg::dss_sw_t     swCtl,
    output dss_pkg::dss_out_t    dout
);

    // Whole state of the block; one process builds the next copy.
    typedef struct packed {
        // Phase and count from integrate start.
        dss_pkg::dss_phase_t phase;
        logic [15:0] cyc;
        logic        busy;
        logic        pol;
        logic        ovr;
        logic        first;

        // Deintegrate count and display word.
        logic [19:0] cnt;
        logic [19:0] disp;
        logic        dispSign;

        // Flags driven to the pins.
        logic        overRange;
        logic        underRange;
        logic        polarity;

        // Scan position and strobe control.
        logic [2:0]  dig;
        logic [7:0]  digCnt;
        logic        longDig;
        logic        strobeSeq;
        logic        blank;
        logic        strobeN;
        logic [4:0]  digSel;
        logic [3:0]  bcd;

        // Restart request and hold control.
        logic        trigPend;
        logic [3:0]  trigCnt;
        logic        holding;
        logic        ctrlHold;

        // Two-stage pin synchronisers.
        logic        runS1;
        logic        runS2;
        logic        cmpS1;
        logic        cmpS2;

        // APB read data and error.
        logic [31:0] rdata;
        logic        slvErr;
    } dss_state_t;

    // Current state and the copy built each clock.
    // Both are one packed struct of one type.
    dss_state_t s_r;
    dss_state_t s_nxt;

    // Pure functions of the state register.
    logic [19:0] cntInc;
    logic [5:0]  carry;
    logic [15:0] endSi;
    logic [15:0] endDi;
    logic [15:0] endZi;
    logic [15:0] endCyc;

    // Phase boundaries as cycle counts from the start of integrate.
    assign endSi  = SI_CLKS - 16'h0001;
    assign endDi  = SI_CLKS + DI_CLKS - 16'h0001;
    // The long discharge follows an over-range.
    assign endZi  = endDi + (s_r.ovr ? ZI_OVR_CLKS : dss_pkg::ZI_CLKS);
    assign endCyc = CYC_CLKS - 16'h0001;

    // Decimal ripple increment of the deintegrate counter, one stage per digit.
    // A nine rolls to zero and passes the carry,
    // so 19999 plus one gives full scale.
    assign carry[0] = 1'b1;
    for (genvar i = 0; i < 5; i++) begin : g_bcd
        logic nine;
        assign nine = (s_r.cnt[4*i +: 4] == 4'h9);
        assign cntInc[4*i +: 4] = !carry[i] ? s_r.cnt[4*i +: 4] :
                                  nine ? 4'h0 : s_r.cnt[4*i +: 4] + 4'h1;
        assign carry[i+1] = carry[i] && nine;
    end

    // Sequencer, scanner, pin filters and register slave in one next-state pass.
    // Later assignments to a field win, so
    // restarts and trigger sets come last.
    always_comb begin
        logic runHigh;
        logic crossing;
        logic restartScan;
        logic apbWr;

        // Locals get a value first on every pass.
        runHigh     = 1'b0;
        crossing    = 1'b0;
        restartScan = 1'b0;
        apbWr       = 1'b0;
        s_nxt       = s_r;

        // Two-flop synchronisers for the asynchronous pins.
        // Only the second stage is read.
        s_nxt.runS1 = runHoldPin;
        s_nxt.runS2 = s_r.runS1;
        s_nxt.cmpS1 = cmpPin;
        s_nxt.cmpS2 = s_r.cmpS1;
        runHigh     = s_r.runS2 && !s_r.ctrlHold;

        // Pulse-width filter: a restart pulse must stay high for the least width.
        // The count saturates while the pin stays high.
        if (!s_r.runS2) begin
            s_nxt.trigCnt = 4'h0;
        end else if (s_r.trigCnt != dss_pkg::TRIG_MIN_CLKS) begin
            s_nxt.trigCnt = s_r.trigCnt + 4'h1;
        end

        // Display scan: each digit 200 clocks, a long first digit 201, MOST_SIGNIFICANT_DIGIT down to LEAST_SIGNIFICANT_DIGIT, then wrap.
        // It never stops; blanking hides it.
        if (s_r.digCnt == (s_r.longDig ? dss_pkg::DIG_LAST_LNG : dss_pkg::DIG_LAST)) begin
            s_nxt.digCnt  = 8'h00;
            s_nxt.longDig = 1'b0;
            if (s_r.dig == dss_pkg::LSD_IDX) begin
                s_nxt.dig = dss_pkg::MSD_IDX;
                if (s_r.strobeSeq) begin
                    s_nxt.strobeSeq = 1'b0;
                    s_nxt.blank     = s_r.ovr;
                end
            end else begin
                s_nxt.dig = s_r.dig - 3'h1;
            end
        end else begin
            s_nxt.digCnt = s_r.digCnt + 8'h01;
        end

        // Phase sequencing against the cycle counter.
        case (s_r.phase)
            // Wait out the cycle, then run or park.
            dss_pkg::PH_AUTOZERO: begin
                if (s_r.cyc >= endCyc) begin
                    if (runHigh || s_r.trigPend) begin
                        s_nxt.phase      = dss_pkg::PH_INTEGRATE;
                        s_nxt.cyc        = 16'h0000;
                        s_nxt.busy       = 1'b1;
                        s_nxt.underRange = 1'b0;
                        s_nxt.trigPend   = 1'b0;
                        s_nxt.holding    = 1'b0;
                    end else begin
                        // Parked: the reading stays up.
                        s_nxt.holding = 1'b1;
                    end
                end else begin
                    s_nxt.cyc = s_r.cyc + 16'h0001;
                end
            end

            // Fixed length; sign taken at its end.
            dss_pkg::PH_INTEGRATE: begin
                s_nxt.cyc = s_r.cyc + 16'h0001;
                if (s_r.cyc == endSi) begin
                    s_nxt.phase     = dss_pkg::PH_DEINT;
                    s_nxt.pol       = s_r.cmpS2;
                    s_nxt.polarity  = s_r.cmpS2;
                    s_nxt.overRange = 1'b0;
                    s_nxt.cnt       = 20'h0_0000;
                    s_nxt.first     = 1'b1;
                    s_nxt.ovr       = 1'b0;
                    s_nxt.blank     = 1'b0;
                    restartScan     = !s_r.strobeSeq;
                end
            end

            // BCD count until the comparator flips.
            dss_pkg::PH_DEINT: begin
                s_nxt.cyc   = s_r.cyc + 16'h0001;
                s_nxt.first = 1'b0;
                // The synchroniser makes the crossing
                // show two counts late.
                crossing    = s_r.cmpS2 != s_r.pol;
                // The first clock is not counted; it pays for the detection delay.
                if (s_r.busy && !s_r.first && !s_r.ovr) begin
                    s_nxt.cnt = cntInc;
                    if (crossing) begin
                        s_nxt.busy       = 1'b0;
                        s_nxt.underRange = cntInc <= dss_pkg::UNDER_BCD;
                    end else if (cntInc == dss_pkg::FULL_BCD) begin
                        s_nxt.ovr = 1'b1;
                    end
                end
                // Fixed-length deintegrate, so busy-to-strobe varies with input.
                // Busy fell earlier, at a varying point.
                if (s_r.cyc == endDi) begin
                    s_nxt.phase     = dss_pkg::PH_ZEROINT;
                    s_nxt.disp      = s_nxt.cnt;
                    s_nxt.dispSign  = s_r.pol;
                    s_nxt.strobeSeq = 1'b1;
                    restartScan     = 1'b1;
                    if (s_nxt.ovr) begin
                        s_nxt.busy      = 1'b0;
                        s_nxt.overRange = 1'b1;
                    end
                end
            end

            // Discharge, longer after over-range.
            dss_pkg::PH_ZEROINT: begin
                s_nxt.cyc = s_r.cyc + 16'h0001;
                if (s_r.cyc == endZi) begin
                    s_nxt.phase = dss_pkg::PH_AUTOZERO;
                    restartScan = !s_r.strobeSeq;
                end
            end
            default: begin
                s_nxt.phase = dss_pkg::PH_AUTOZERO;
            end
        endcase

        // A restart puts the MOST_SIGNIFICANT_DIGIT up for one extra count.
        // This keeps the first strobe 101 counts
        // after the end of the cycle.
        if (restartScan) begin
            s_nxt.dig     = dss_pkg::MSD_IDX;
            s_nxt.digCnt  = 8'h00;
            s_nxt.longDig = 1'b1;
        end

        // Restart requests count only once the cycle has completed.
        // A pulse counts only where the filter fills,
        // so a long high cannot re-arm a used request.
        if (s_r.holding && s_r.runS2 &&
            s_r.trigCnt == dss_pkg::TRIG_MIN_CLKS - 4'h1) begin
            s_nxt.trigPend = 1'b1;
        end

        // APB: read data is prepared in the setup cycle, writes act in access.
        // Unmapped reads give zero and an error.
        apbWr = psel && penable && pwrite;
        if (psel && !penable) begin
            s_nxt.slvErr = 1'b0;
            case (paddr)
                dss_pkg::CTRL_ADDR: s_nxt.rdata = {31'h0000_0000, s_r.ctrlHold};
                dss_pkg::STAT_ADDR: s_nxt.rdata = {24'h00_0000, s_r.holding,
                                        s_r.phase, s_r.underRange, s_r.overRange,
                                        s_r.polarity, s_r.busy, s_r.trigPend};
                dss_pkg::RSLT_ADDR: s_nxt.rdata = {11'h000, s_r.dispSign, s_r.disp};
                default: begin
                    s_nxt.rdata  = 32'h0000_0000;
                    s_nxt.slvErr = 1'b1;
                end
            endcase
        end
        if (apbWr && paddr == dss_pkg::CTRL_ADDR) begin
            s_nxt.ctrlHold = pwdata[dss_pkg::CTRL_HOLD_BIT];
            // Set after any clear above, so a trigger in the consume cycle survives.
            if (pwdata[dss_pkg::CTRL_TRIG_BIT] && s_r.holding) begin
                s_nxt.trigPend = 1'b1;
            end
        end

        // Registered display outputs: one select, BCD switching on the same edge.
        // Next-state copies keep select, BCD
        // and strobe moving on one edge.
        s_nxt.digSel  = s_nxt.blank ? 5'h00 : 5'(5'h01 << s_nxt.dig);
        s_nxt.bcd     = s_nxt.disp[{s_nxt.dig, 2'b00} +: 4];
        s_nxt.strobeN = !(s_nxt.strobeSeq && s_nxt.digCnt ==
                          (s_nxt.longDig ? dss_pkg::STB_AT_LNG : dss_pkg::STB_AT));
    end

    // State register; the clock enable freezes everything including the bus.
    // Reset parks in auto-zero, MOST_SIGNIFICANT_DIGIT selected,
    // strobe idle high and the reading held.
    // Reset ignores ce so it always takes.
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r         <= '0;
            s_r.dig     <= dss_pkg::MSD_IDX;
            s_r.strobeN <= 1'b1;
            s_r.holding <= 1'b1;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Analog switches follow the phase directly.
    // One phase switch is on at any time;
    // break-before-make is left to the drivers.
    always_comb begin
        swCtl.azOn   = s_r.phase == dss_pkg::PH_AUTOZERO;
        swCtl.inOn   = s_r.phase == dss_pkg::PH_INTEGRATE;
        swCtl.refOn  = s_r.phase == dss_pkg::PH_DEINT;
        swCtl.refNeg = swCtl.refOn && s_r.pol;
        swCtl.ziOn   = s_r.phase == dss_pkg::PH_ZEROINT;
    end

    // Outputs to latches and the processor side.
    // Every pin comes from a flip-flop, so the
    // latches never see decode glitches.
    always_comb begin
        dout.digitSelectLines = s_r.digSel;
        dout.bcdValueLines    = s_r.bcd;
        dout.strobeN          = s_r.strobeN;
        dout.busy             = s_r.busy;
        dout.polarity         = s_r.polarity;
        dout.overRange        = s_r.overRange;
        dout.underRange       = s_r.underRange;
    end

    // Zero wait states: pready follows ce, so a
    // frozen block stretches the access phase.
    assign prdata  = s_r.rdata;
    assign pslverr = s_r.slvErr && psel && penable;
    assign pready  = ce;

endmodule

`default_nettype wire

// File: logic/dss_pkg.sv
// Package for the dual-slope conversion sequencer: timing counts, register map,
// phase enumeration and the packed carriers shared by the design and its bench.
// Assumes a single 25 MHz clock and an APB master with 32-bit data.
// Function
// - Phases: auto-zero, integrate, deintegrate, zero-integrator, repeat.
// - Auto-zero grounds inputs and charges reference capacitor.
// - Integrate inputs fixed count, then record sign.
// - Deintegrate with signed reference, count to crossing.
// - Zero-integrator lasts 200 clocks, 6200 after over-range.
// - Gate high: new cycle every 40002 clocks.
// - Gate low: finish cycle, then hold reading.
// - Pulse over 300 ns restarts; early pulse ignored.
// - First strobe 101 counts after cycle end.
// - Cycle end: MOST_SIGNIFICANT_DIGIT on lines, strobe mid-digit.
// - Strobe per digit, MOST_SIGNIFICANT_DIGIT down to LEAST_SIGNIFICANT_DIGIT.
// - Keep scanning without strobes, except after over-range.
// - Busy spans integrate until first clock after crossing.
// - First MOST_SIGNIFICANT_DIGIT select in auto-zero, deintegrate one longer.
// - Busy fall to strobe varies with input.
// - Digit selects 200 clocks each; blank on over-range.
// - Sign output updates at each deintegrate start.
// - Over-range flag: busy fall until next deintegrate.
// - Under-range flag when result at most 1800.

`default_nettype none

package dss_pkg;

    // Clock rate and the least width of a restart pulse on the gate pin.
    localparam int CLK_MHZ       = 25;
    localparam int TRIG_MIN_NS   = 300;
    localparam logic [3:0] TRIG_MIN_CLKS = 4'((TRIG_MIN_NS * CLK_MHZ + 999) / 1000);

    // Conversion timing in clocks; the long ones are also top-level parameters.
    localparam logic [15:0] CYC_CLKS     = 16'h9C42;   // 40002 clocks per cycle.
    localparam logic [15:0] SI_CLKS      = 16'h2710;   // 10000 integrate clocks.
    localparam logic [15:0] DI_CLKS      = 16'h4E21;   // 20001 deintegrate clocks.
    localparam logic [15:0] ZI_CLKS      = 16'h00C8;   // 200 zero-integrator clocks.
    localparam logic [15:0] ZI_OVR_CLKS  = 16'h1838;   // 6200 after over-range.

    // Display scan: 200 clocks per digit, strobe after 100 counts of a digit, 101 in a long first digit.
    localparam logic [7:0]  DIG_LAST     = 8'hC7;
    localparam logic [7:0]  DIG_LAST_LNG = 8'hC8;
    localparam logic [7:0]  STB_AT       = 8'h64;
    localparam logic [7:0]  STB_AT_LNG   = 8'h65;
    localparam logic [2:0]  MSD_IDX      = 3'h4;
    localparam logic [2:0]  LSD_IDX      = 3'h0;

    // Result limits, packed BCD: full scale 20000, under-range at or below 1800.
    localparam logic [19:0] FULL_BCD     = 20'h2_0000;
    localparam logic [19:0] UNDER_BCD    = 20'h0_1800;

    // Register map, byte addresses, and field positions.
    localparam logic [11:0] CTRL_ADDR    = 12'h000;
    localparam logic [11:0] STAT_ADDR    = 12'h004;
    localparam logic [11:0] RSLT_ADDR    = 12'h008;
    localparam int CTRL_HOLD_BIT = 0;
    localparam int CTRL_TRIG_BIT = 1;
    localparam int RSLT_SIGN_BIT = 20;

    typedef enum logic [1:0] {
        PH_AUTOZERO,
        PH_INTEGRATE,
        PH_DEINT,
        PH_ZEROINT
    } dss_phase_t;

    // Analog switch controls towards the front end.
    typedef struct packed {
        logic azOn;
        logic inOn;
        logic refOn;
        logic refNeg;
        logic ziOn;
    } dss_sw_t;

    // Display and handshake outputs towards latches or a processor.
    typedef struct packed {
        logic [4:0] digitSelectLines;
        logic [3:0] bcdValueLines;
        logic       strobeN;
        logic       busy;
        logic       polarity;
        logic       overRange;
        logic       underRange;
    } dss_out_t;

endpackage

`default_nettype wire

// File: bench/dss_sequencer_chk.sv
// Concurrent checks on the conversion sequencer ports, bound in from the bench.
// Assumes ce stays high, so one count equals one mclk.
`default_nettype none
module dss_sequencer_chk #(
    parameter logic [15:0] CYC_CLKS    = dss_pkg::CYC_CLKS,
    parameter logic [15:0] SI_CLKS     = dss_pkg::SI_CLKS,
    parameter logic [15:0] DI_CLKS     = dss_pkg::DI_CLKS,
    parameter logic [15:0] ZI_OVR_CLKS = dss_pkg::ZI_OVR_CLKS
) (
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              ce,
    input wire logic              runHoldPin,
    input wire logic              cmpPin,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire dss_pkg::dss_sw_t  swCtl,
    input wire dss_pkg::dss_out_t dout
);
    logic [15:0] inCnt_r;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Counts integrate clocks, so a wrong fixed length shows at the end of the phase.
    always_ff @(posedge mclk) begin
        if (rst || !swCtl.inOn) begin
            inCnt_r <= 16'h0000;
        end else begin
            inCnt_r <= inCnt_r + 16'h0001;
        end
    end

    // A digit must not move while an external latch is taking it.
    sequence selHeld;
        ($onehot(dout.digitSelectLines) && $stable(dout.digitSelectLines)) [*8];
    endsequence
    sequence intDone;
        (inCnt_r == SI_CLKS) && swCtl.refOn && !swCtl.inOn;
    endsequence

    // Phase order, busy framing and the display handshake.
    chk_one_select: assert property ($onehot0(dout.digitSelectLines))
        else $error("several digit selects high");
    chk_bcd_follows: assert property ($changed(dout.bcdValueLines) |->
        $changed(dout.digitSelectLines) || $rose(swCtl.ziOn)) else $error("bcd moved alone");
    chk_strobe_short: assert property ($fell(dout.strobeN) |=> dout.strobeN)
        else $error("strobe low too long");
    chk_strobe_mid: assert property ($fell(dout.strobeN) |-> selHeld)
        else $error("digit select moved around strobe");
    chk_integrate_len: assert property ($fell(swCtl.inOn) |-> intDone)
        else $error("integrate length or next phase wrong");
    chk_zero_follows: assert property ($fell(swCtl.refOn) |-> swCtl.ziOn)
        else $error("deintegrate not followed by zero integrator");
    chk_busy_start: assert property ($rose(dout.busy) |->
        swCtl.inOn && !swCtl.azOn) else $error("busy rose outside integrate start");
    chk_busy_end: assert property ($fell(dout.busy) |-> swCtl.refOn || swCtl.ziOn)
        else $error("busy fell outside deintegrate");
    chk_sign_update: assert property ($changed(dout.polarity) |-> $rose(swCtl.refOn))
        else $error("sign changed outside deintegrate start");
    chk_under_clear: assert property ($rose(swCtl.inOn) |-> ##[0:1] !dout.underRange)
        else $error("under-range not cleared");
    chk_over_clear: assert property ($rose(swCtl.refOn) |-> ##[0:1] !dout.overRange)
        else $error("over-range not cleared");
endmodule
`default_nettype wire

// File: bench/dss_latch_model.sv
// Far-side model: a latch bank taking digits on strobe and a busy-gated clock counter.
// Assumes strobeN is a one-clock low pulse seen on the rising mclk edge.
`default_nettype none
module dss_latch_model (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire dss_pkg::dss_out_t dout,
    output logic [19:0]            latched_r,
    output logic [15:0]            busyCnt_r,
    output logic [3:0]             strobeCnt_r
);
    logic busyWas_r;

    // Busy clocks restart at each busy rise; strobes are counted per conversion.
    always_ff @(posedge mclk) begin
        if (rst) begin
            latched_r   <= 20'h0_0000;
            busyCnt_r   <= 16'h0000;
            strobeCnt_r <= 4'h0;
            busyWas_r   <= 1'b0;
        end else begin
            busyWas_r <= dout.busy;
            if (dout.busy) begin
                busyCnt_r <= busyWas_r ? busyCnt_r + 16'h0001 : 16'h0001;
            end
            if (dout.busy && !busyWas_r) begin
                strobeCnt_r <= 4'h0;
            end
            // The digit under select is taken while strobe is low.
            if (!dout.strobeN) begin
                strobeCnt_r <= strobeCnt_r + 4'h1;
                for (int i = 0; i < 5; i++) begin
                    if (dout.digitSelectLines[i]) begin
                        latched_r[4*i +: 4] <= dout.bcdValueLines;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/dss_sequencer_tb.sv
// Self-checking bench for the conversion sequencer, with a latch model on its outputs.
// Assumes shortened conversion counts; the cycle-period and busy-count expectations are derived from them.
`default_nettype none
`define DSS_CHECK(got, exp, msg) begin nCompared++; if ((got) !== (exp)) begin \
    nMismatch++; $display("mismatch at %0t: %s", $time, msg); end end

module dss_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] SI  = 16'h0020;
    localparam logic [15:0] DI  = 16'h0041;
    localparam logic [15:0] ZIO = 16'h0040;
    localparam logic [15:0] CYC = 16'h0200;

    logic              mclk, rst, ce, runHoldPin, cmpPin, psel, penable, pwrite;
    logic              pready, pslverr, rdErr;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rdData;
    logic [19:0]       latched;
    logic [15:0]       busyCnt;
    logic [3:0]        strobeCnt;
    dss_pkg::dss_sw_t  swCtl;
    dss_pkg::dss_out_t dout;
    int                nMismatch = 0;
    int                nCompared = 0;
    int                cycles = 0;

    dss_sequencer #(.CYC_CLKS(CYC), .SI_CLKS(SI), .DI_CLKS(DI), .ZI_OVR_CLKS(ZIO))
    dss_sequencer_inst (
        .mclk(mclk), .rst(rst), .ce(ce), .runHoldPin(runHoldPin), .cmpPin(cmpPin),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .swCtl(swCtl), .dout(dout)
    );
    dss_latch_model dss_latch_model_inst (
        .mclk(mclk), .rst(rst), .dout(dout), .latched_r(latched), .busyCnt_r(busyCnt),
        .strobeCnt_r(strobeCnt)
    );

    // Free-running 25 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Cuts a hung wait short; the planned run needs well under this.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            nMismatch++;
            printVerdict();
        end
    end

    task automatic printVerdict();
        if (nMismatch == 0 && nCompared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One APB transfer; an idle edge follows so a new setup never shares a time step.
    task automatic apbXfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    function automatic int bcdBin(input logic [19:0] b);
        return b[19:16] * 10000 + b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0];
    endfunction

    // A gate pulse of ten clocks, longer than the least restart pulse.
    task automatic pulseGate();
        runHoldPin <= 1'b1;
        repeat (10) @(posedge mclk);
        runHoldPin <= 1'b0;
    endtask

    task automatic tReset();
        `DSS_CHECK({dout.busy, swCtl.azOn}, 2'b01, "state after reset")
        apbXfer(12'h00C, 1'b0, 32'h0000_0000);
        `DSS_CHECK({rdErr, rdData}, {1'b1, 32'h0000_0000}, "unmapped read")
    endtask

    // One held conversion: start by free run (0), gate pulse (1) or trigger write (2).
    task automatic tConvert(input logic pos, input int n, input int how);
        int t;
        logic [19:0] res;
        cmpPin <= pos;
        repeat (4) @(posedge mclk);
        if (how == 1) pulseGate();
        if (how == 2) apbXfer(dss_pkg::CTRL_ADDR, 1'b1, 32'h0000_0002);
        do @(posedge mclk); while (dout.busy !== 1'b1);
        `DSS_CHECK({swCtl.inOn, swCtl.azOn}, 2'b10, "integrate switches")
        runHoldPin <= 1'b0;
        repeat (4) @(posedge mclk);
        pulseGate();
        do @(posedge mclk); while (swCtl.refOn !== 1'b1);
        `DSS_CHECK({dout.polarity, swCtl.refNeg}, {pos, pos}, "recorded sign")
        repeat (n) @(posedge mclk);
        cmpPin <= ~pos;
        do @(posedge mclk); while (dout.busy !== 1'b0);
        @(posedge mclk);
        `DSS_CHECK(dout.underRange, 1'b1, "small result flag")
        do @(posedge mclk); while (swCtl.ziOn !== 1'b1);
        t = 0;
        do begin @(posedge mclk); t++; end while (dout.strobeN !== 1'b0);
        `DSS_CHECK(t, 101, "first strobe delay")
        do begin @(posedge mclk); t++; end while (dout.digitSelectLines === 5'b10000);
        `DSS_CHECK(t, 201, "long first digit")
        `DSS_CHECK(dout.digitSelectLines, 5'b01000, "scan order")
        t = 0;
        do begin @(posedge mclk); t++; end while (dout.digitSelectLines === 5'b01000);
        `DSS_CHECK(t, 200, "digit length")
        repeat (1000) @(posedge mclk);
        `DSS_CHECK({strobeCnt, dout.busy}, {4'h5, 1'b0}, "strobes then hold")
        `DSS_CHECK($onehot(dout.digitSelectLines), 1'b1, "scan goes on")
        apbXfer(dss_pkg::RSLT_ADDR, 1'b0, 32'h0000_0000);
        res = rdData[19:0];
        `DSS_CHECK({rdData[20], res}, {pos, latched}, "result and latched digits")
        `DSS_CHECK(busyCnt, 16'(bcdBin(res) + SI + 1), "busy clock count")
        `DSS_CHECK(bcdBin(res) inside {[n:n + 4]}, 1'b1, "count to crossing")
    endtask

    // With the gate high, integrate starts repeat at the full cycle length.
    task automatic tPeriod();
        int t;
        runHoldPin <= 1'b1;
        do @(posedge mclk); while (swCtl.inOn !== 1'b1);
        t = 0;
        do begin @(posedge mclk); t++; end while (swCtl.inOn !== 1'b0);
        do begin @(posedge mclk); t++; end while (swCtl.inOn !== 1'b1);
        `DSS_CHECK(t, int'(CYC), "cycle period")
    endtask

    // Reset, then the scenarios in turn.
    initial begin
        ce         = 1'b1;
        rst        = 1'b1;
        runHoldPin = 1'b1;
        cmpPin     = 1'b1;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h0000_0000;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        tReset();
        tConvert(1'b1, 10, 0);
        tConvert(1'b0, 25, 1);
        tConvert(1'b1, 40, 2);
        tPeriod();
        printVerdict();
    end
endmodule

bind dss_sequencer dss_sequencer_chk #(
    .CYC_CLKS(CYC_CLKS), .SI_CLKS(SI_CLKS), .DI_CLKS(DI_CLKS), .ZI_OVR_CLKS(ZI_OVR_CLKS)
) dss_sequencer_chk_inst (
    .mclk(mclk), .rst(rst), .ce(ce), .runHoldPin(runHoldPin), .cmpPin(cmpPin), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .swCtl(swCtl), .dout(dout)
);
`default_nettype wire
